//--- design/ida_pkg.sv
package ida_pkg;
    // APB register map, byte addresses
    localparam logic [11:0] REG_PTR_ADDR   = 12'h000;
    localparam logic [11:0] REG_PORT_ADDR  = 12'h004;
    localparam logic [11:0] REG_CFG_ADDR   = 12'h008;
    localparam logic [11:0] REG_CLR_ADDR   = 12'h00c;
    localparam logic [11:0] WIN_BASE_ADDR  = 12'h400;
    localparam int          WIN_IDX_LSB    = 2;
    // Pointer field layout
    localparam int          LOW_BITS       = 5;
    localparam int          PTR_W          = 8;
    localparam logic [7:0]  PORT_SELF      = 8'h00;
    localparam logic [7:0]  PTR_RESET      = 8'h00;
    localparam logic [7:0]  READ_ZERO      = 8'h00;
    // Variant codes for the implemented pointer width
    localparam int          VARIANT_SMALL  = 5;
    localparam int          VARIANT_MID    = 7;
    localparam int          VARIANT_LARGE  = 8;
    localparam int          MAX_BANKS      = 8;
    localparam int          LOCS_PER_BANK  = 32;
endpackage

//--- design/ida_mem.sv
`timescale 1ns/1ps
// Data memory with registered read port
module ida_mem #(
    parameter int DEPTH = 256,
    parameter int AW    = 8
) (
    input  wire logic          pclk,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [7:0]    wdata,
    input  wire logic [AW-1:0] raddr,
    output logic      [7:0]    rdata
);
    logic [7:0] mem [DEPTH];

    // Write and registered read; no reset on storage
    always_ff @(posedge pclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule

//--- design/ida_ptr.sv
`timescale 1ns/1ps
// Pointer register with variant dependent implemented bits
module ida_ptr #(
    parameter int PTR_BITS = 8
) (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       load,
    input  wire logic [7:0] load_val,
    output logic      [7:0] ptr_q
);
    // Implemented-bit mask; unimplemented bits forced to one
    localparam logic [7:0] IMPL_MASK = 8'(({8'hff} >> (8 - PTR_BITS)));
    logic [7:0] ptr_r;

    // Mask arithmetic only holds for five to eight implemented bits
    initial begin
        if (PTR_BITS < ida_pkg::VARIANT_SMALL || PTR_BITS > ida_pkg::VARIANT_LARGE) begin
            $error("ida_ptr: PTR_BITS out of range");
        end
    end

    // Load path; only implemented bits are stored, so a clear stores all zeros
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ptr_r <= ida_pkg::PTR_RESET;
        end else if (load) begin
            ptr_r <= load_val & IMPL_MASK;
        end
    end

    // Unimplemented bits read as one whatever was stored
    always_comb begin
        ptr_q = ptr_r | ~IMPL_MASK;
    end
endmodule

//--- design/ida_top.sv
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
module ida_top #(
    parameter int PTR_BITS = ida_pkg::VARIANT_LARGE
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr
);
    localparam int AW        = PTR_BITS;

    // Only the three documented variants are served
    initial begin
        if (PTR_BITS != ida_pkg::VARIANT_SMALL && PTR_BITS != ida_pkg::VARIANT_MID &&
            PTR_BITS != ida_pkg::VARIANT_LARGE) begin
            $error("ida_top: PTR_BITS must be 5, 7 or 8");
        end
    end

    typedef enum logic [1:0] {
        IDA_IDLE,
        IDA_WAIT,
        IDA_DONE
    } ida_state_e;

    ida_state_e  state_r;
    logic [31:0] prdata_r;
    logic        pready_r;
    logic        pslverr_r;
    logic [7:0]  ptr_q;
    logic        ptr_load;
    logic [7:0]  ptr_val;
    logic        mem_we;
    logic [AW-1:0] mem_waddr;
    logic [AW-1:0] mem_raddr;
    logic [7:0]  mem_wdata;
    logic [7:0]  mem_rdata;
    logic [AW-1:0] eff_addr;
    logic        ptr_self;
    logic        acc;
    logic        is_ptr;
    logic        is_port;
    logic        is_cfg;
    logic        is_clr;
    logic        is_win;
    logic [AW-1:0] win_addr;
    logic        port_rd_r;
    logic        mapped;

    // Effective address from bank and low bits; no bank on small variant
    always_comb begin
        eff_addr = ptr_q[AW-1:0];
        ptr_self = (ptr_q[AW-1:0] == '0);
    end

    // Access decode; the window gives software direct data-memory view
    always_comb begin
        acc      = psel && penable && (state_r == IDA_IDLE);
        is_ptr   = (paddr == ida_pkg::REG_PTR_ADDR);
        is_port  = (paddr == ida_pkg::REG_PORT_ADDR);
        is_cfg   = (paddr == ida_pkg::REG_CFG_ADDR);
        is_clr   = (paddr == ida_pkg::REG_CLR_ADDR);
        // Nine-bit compare so an eight-bit variant still sees its 256 entries
        is_win   = (paddr[11:10] == ida_pkg::WIN_BASE_ADDR[11:10]) &&
                   ({1'b0, paddr[9:ida_pkg::WIN_IDX_LSB]} < 9'(1 << AW));
        win_addr = paddr[ida_pkg::WIN_IDX_LSB +: AW];
        mapped   = is_ptr || is_port || is_cfg || is_clr || is_win;
    end

    // Pointer writes: plain store, or the clear command
    always_comb begin
        ptr_load = acc && pwrite && (is_ptr || is_clr);
        ptr_val  = is_clr ? 8'h00 : pwdata[7:0];
    end

    // Port writes go to memory unless the pointer names the port itself
    always_comb begin
        mem_we    = acc && pwrite && ((is_port && !ptr_self) || is_win);
        mem_waddr = is_win ? win_addr : eff_addr;
        mem_wdata = pwdata[7:0];
        mem_raddr = is_win ? win_addr : eff_addr;
    end

    ida_ptr #(
        .PTR_BITS (PTR_BITS)
    ) i_ida_ptr (
        .pclk     (pclk),
        .presetn  (presetn),
        .load     (ptr_load),
        .load_val (ptr_val),
        .ptr_q    (ptr_q)
    );

    ida_mem #(
        .DEPTH (1 << AW),
        .AW    (AW)
    ) i_ida_mem (
        .pclk  (pclk),
        .we    (mem_we),
        .waddr (mem_waddr),
        .wdata (mem_wdata),
        .raddr (mem_raddr),
        .rdata (mem_rdata)
    );

    // Reads of memory need one wait cycle for the registered read port
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r   <= IDA_IDLE;
            port_rd_r <= 1'b0;
        end else begin
            case (state_r)
                IDA_IDLE: begin
                    if (acc && !pwrite && (is_port || is_win)) begin
                        state_r   <= IDA_WAIT;
                        port_rd_r <= is_port && ptr_self;
                    end else if (acc) begin
                        state_r <= IDA_DONE;
                    end
                end
                IDA_WAIT: begin
                    state_r <= IDA_DONE;
                end
                IDA_DONE: begin
                    state_r <= IDA_IDLE;
                end
                default: begin
                    state_r <= IDA_IDLE;
                end
            endcase
        end
    end

    // Response registers; pready pulses in DONE
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r  <= 32'h0000_0000;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            if (state_r == IDA_WAIT) begin
                pready_r <= 1'b1;
                prdata_r <= port_rd_r ? {24'h00_0000, ida_pkg::READ_ZERO}
                                      : {24'h00_0000, mem_rdata};
            end else if (state_r == IDA_IDLE && acc && !(!pwrite && (is_port || is_win))) begin
                pready_r  <= 1'b1;
                pslverr_r <= !mapped;
                // Read data only moves on a read answer; writes leave it standing
                if (!pwrite) begin
                    if (is_ptr) begin
                        prdata_r <= {24'h00_0000, ptr_q};
                    end else if (is_cfg) begin
                        prdata_r <= 32'(PTR_BITS);
                    end else begin
                        prdata_r <= 32'h0000_0000;
                    end
                end
            end
        end
    end

    always_comb begin
        prdata  = prdata_r;
        pready  = pready_r;
        pslverr = pslverr_r;
    end
endmodule

//--- verification/ida_top_sva.sv
`timescale 1ns/1ps
// Bus timing and read value checks
module ida_top_sva #(
    parameter int PTR_BITS = 8
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Answer pulses follow a live request only
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    ready_cause_a: assert property (pready |-> $past(psel && penable))
        else $error("pready without request");
    // Writes take one wait state, port reads two
    write_lat_a: assert property ((psel && !penable && pwrite) ##1 penable |=> pready)
        else $error("write answer late");
    port_lat_a: assert property ((psel && !penable && !pwrite
        && paddr == ida_pkg::REG_PORT_ADDR) ##1 penable |=> !pready ##1 pready)
        else $error("port read answer timing");
    cfg_width_a: assert property ((psel && !penable && !pwrite
        && paddr == ida_pkg::REG_CFG_ADDR) ##1 penable |=> prdata == 32'(PTR_BITS))
        else $error("variant width wrong");
    // Bit seven is unimplemented below eight bits and must read one
    ptr_top_a: assert property ((psel && !penable && !pwrite
        && paddr == ida_pkg::REG_PTR_ADDR) ##1 penable |=> (PTR_BITS == 8 || prdata[7]))
        else $error("pointer top bit not one");
    upper_zero_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    rdata_hold_a: assert property (!(pready && !pwrite) |-> $stable(prdata))
        else $error("read data moved without read");
endmodule
bind ida_top ida_top_sva #(.PTR_BITS(PTR_BITS)) i_ida_top_sva (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

//--- verification/ida_top_bench.sv
`timescale 1ns/1ps
// Seven-bit variant: exercises bank bit 5 and one unimplemented bit
module ida_top_bench;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [31:0] rd;
    logic        err;
    int          fails = 0;
    int          total_checks = 0;
    localparam logic [11:0] PTR = ida_pkg::REG_PTR_ADDR;
    localparam logic [11:0] PRT = ida_pkg::REG_PORT_ADDR;
    ida_top #(.PTR_BITS(7)) i_ida_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    // Clock, 50 ns period
    initial begin
        forever #25 pclk = ~pclk;
    end
    task automatic tally_and_finish();
        if (fails == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One APB transfer; entered just after a rising edge, leaves an idle cycle
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
            if (n > 20) begin
                fails++;
                tally_and_finish();
            end
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask
    // Direct window into data memory, one word per location
    function automatic logic [11:0] win(input logic [7:0] n);
        return ida_pkg::WIN_BASE_ADDR + {2'b00, n, 2'b00};
    endfunction
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdc("cfg", ida_pkg::REG_CFG_ADDR, 32'h7);
        rdc("ptr_reset", PTR, 32'h80);
        apb(1'b1, win(8'h00), 32'h33);
        apb(1'b1, win(8'h08), 32'h10);
        apb(1'b1, win(8'h29), 32'h0a);
        apb(1'b1, PTR, 32'h08);
        rdc("port_08", PRT, 32'h10);
        apb(1'b1, PTR, 32'h29);
        rdc("ptr_29", PTR, 32'ha9);
        rdc("port_29", PRT, 32'h0a);
        apb(1'b1, PRT, 32'h5a);
        rdc("win_29", win(8'h29), 32'h5a);
        // Implemented bits zero: port points at itself
        apb(1'b1, PTR, 32'h80);
        rdc("port_self", PRT, 32'h0);
        apb(1'b1, PRT, 32'h77);
        rdc("win_00", win(8'h00), 32'h33);
        apb(1'b1, PTR, 32'h7f);
        apb(1'b1, ida_pkg::REG_CLR_ADDR, 32'hff);
        rdc("ptr_clear", PTR, 32'h80);
        rdc("unmapped", 12'h010, 32'h0);
        chk("unmapped_err", 32'h1, {31'h0, err});
        tally_and_finish();
    end
endmodule
